// file: cpd_card_model.sv
`timescale 1ns/1ns
`default_nettype none

// ----------------------------------------------------------------------
// Card seen through the receiver: one I/Q sample stream while field on
// ----------------------------------------------------------------------
module cpd_card_model (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_field,
  input wire logic i_slow,
  input wire logic [15:0] i_quiet,
  input wire logic [11:0] i_lvl_i,
  input wire logic [11:0] i_lvl_q,
  output logic o_valid,
  output logic [11:0] o_i,
  output logic [11:0] o_q
);
  logic [15:0] age_r = 16'h0000;
  logic v_r = 1'b0;
  logic [11:0] i_r = 12'h000;
  logic [11:0] q_r = 12'h000;
  logic good;

  assign good = (!i_slow || age_r[0]) && (age_r >= i_quiet);
  assign o_valid = v_r;
  assign o_i = i_r;
  assign o_q = q_r;

  // Junk samples while the receiver settles, inverted data when idle
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      age_r <= 16'h0000;
      v_r <= 1'b0;
    end else begin
      if (i_field && age_r != 16'hffff) begin
        age_r <= age_r + 16'h0001;
      end else if (!i_field) begin
        age_r <= 16'h0000;
      end
      v_r <= i_field && (!i_slow || age_r[0]);
      i_r <= (i_field && good) ? i_lvl_i : ~i_lvl_i;
      q_r <= (i_field && good) ? i_lvl_q : ~i_lvl_q;
    end
  end
endmodule // cpd_card_model

`default_nettype wire

// file: cpd_chan.sv
`timescale 1ns/1ns
`default_nettype none
`include "cpd_map.svh"

module cpd_chan (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_clear,
  input wire logic i_valid,
  input wire logic [`CPD_ADC_W-1:0] i_sample,
  input wire logic [2:0] i_n,
  input wire logic [15:0] i_ref,
  input wire logic [15:0] i_thr,
  output logic o_done,
  output logic o_over,
  output logic [15:0] o_avg
);

  cpd_pkg::cpd_chan_s_t s_r;
  cpd_pkg::cpd_chan_s_t s_nxt;
  logic [6:0] target;
  logic [6:0] cnt_inc;
  logic [`CPD_SUM_W-1:0] sum_add;
  logic [`CPD_DIFF_W-1:0] sum_ext;
  logic [`CPD_DIFF_W-1:0] ref_sc;
  logic [`CPD_DIFF_W-1:0] diff;

  // ----------------------------------------------------------------------
  // Accumulate and compare in the summed domain
  // ----------------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    target = 7'h01 << i_n;
    cnt_inc = s_r.cnt + 7'h01;
    sum_add = s_r.sum + {{(`CPD_SUM_W-`CPD_ADC_W){1'b0}}, i_sample};
    sum_ext = {{(`CPD_DIFF_W-`CPD_SUM_W){1'b0}}, sum_add};
    // Reference scaled by 2^n so the threshold counts LSB/2^n
    ref_sc = {{(`CPD_DIFF_W-16){1'b0}}, i_ref} << i_n;
    diff = (sum_ext >= ref_sc) ? (sum_ext - ref_sc) : (ref_sc - sum_ext);
    if (i_clear) begin
      s_nxt = '0;
    end else if (i_valid && !s_r.done) begin
      s_nxt.cnt = cnt_inc;
      s_nxt.sum = sum_add;
      if (cnt_inc == target) begin
        s_nxt.done = 1'b1;
        s_nxt.avg = 16'(sum_add >> i_n);
        s_nxt.over = diff > {{(`CPD_DIFF_W-16){1'b0}}, i_thr};
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign o_done = s_r.done;
  assign o_over = s_r.over;
  assign o_avg = s_r.avg;

  sample_count_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    $rose(s_r.done) |-> s_r.cnt == (7'h01 << i_n))
    else $error("average finished on wrong sample count");

endmodule // cpd_chan

`default_nettype wire

// file: cpd_map.svh
// Overview of operation
// - Average 2^n I/Q samples, n 0..6
// - Load RSSI target into receiver register
// - Load RSSI hysteresis into receiver register
// - Detection runs only when enable bit set
// - Bit 5: RF off before regulator off
// - Threshold: Q in 31:16, I in 15:0
// - Threshold unit is ADC LSB over 2^n
// - Card detected if either channel exceeds
// - Wait settle delay in us before averaging
`ifndef CPD_MAP_SVH
`define CPD_MAP_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define CPD_ADDR_W 11
`define CPD_ADDR_AVG 11'h3de
`define CPD_ADDR_RSSI_TGT 11'h3e0
`define CPD_ADDR_RSSI_HYST 11'h3e2
`define CPD_ADDR_CTRL 11'h3e3
`define CPD_ADDR_THR 11'h3e6
`define CPD_ADDR_SETTLE 11'h3f7
`define CPD_ADDR_STATUS 11'h400
`define CPD_ADDR_MASK 11'h401
`define CPD_ADDR_CMD 11'h402
`define CPD_ADDR_REF 11'h404
`define CPD_ADDR_MEAS 11'h405

// ----------------------------------------------------------------------
// Fields
// ----------------------------------------------------------------------
`define CPD_CTRL_EN_BIT 7
`define CPD_CTRL_RFOFF_BIT 5
`define CPD_CMD_MEAS_BIT 0
`define CPD_CMD_CAL_BIT 1
`define CPD_STS_DET_BIT 0
`define CPD_STS_DONE_BIT 1
`define CPD_AVG_N_MAX 3'h6
`define CPD_ADC_W 12
`define CPD_SUM_W 18
`define CPD_DIFF_W 23

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define CPD_AVG_RST 3'h0
`define CPD_RSSI_TGT_RST 16'h0000
`define CPD_RSSI_HYST_RST 8'h00
`define CPD_THR_RST 32'h0000_0000
`define CPD_SETTLE_RST 16'h0014

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define CPD_CLK_PERIOD_NS 4
`define CPD_DELAY_UNIT_NS 1000
`define CPD_UNIT_CYCLES ((`CPD_DELAY_UNIT_NS + `CPD_CLK_PERIOD_NS - 1) / `CPD_CLK_PERIOD_NS)

`endif

// file: cpd_pkg.sv
`default_nettype none
`include "cpd_map.svh"

package cpd_pkg;

  typedef enum logic [5:0] {
    CPD_IDLE = 6'b000001,
    CPD_SETTLE = 6'b000010,
    CPD_AVG = 6'b000100,
    CPD_CMP = 6'b001000,
    CPD_FOFF = 6'b010000,
    CPD_ROFF = 6'b100000
  } cpd_state_t;

  typedef struct packed {
    cpd_state_t st;
    logic [2:0] avg_n;
    logic [15:0] rssi_tgt;
    logic [7:0] rssi_hyst;
    logic det_en;
    logic rf_off_early;
    logic [31:0] thr;
    logic [15:0] settle;
    logic [1:0] sts;
    logic [1:0] msk;
    logic [31:0] refv;
    logic calib;
    logic rf_on;
    logic reg_en;
    logic rssi_load;
    logic [31:0] rdata;
  } cpd_top_s_t;

  typedef struct packed {
    logic [6:0] cnt;
    logic [`CPD_SUM_W-1:0] sum;
    logic done;
    logic over;
    logic [15:0] avg;
  } cpd_chan_s_t;

  typedef struct packed {
    logic busy;
    logic done;
    logic [7:0] sub;
    logic [15:0] us;
  } cpd_tmr_s_t;

endpackage

`default_nettype wire

// file: cpd_timer.sv
`timescale 1ns/1ns
`default_nettype none
`include "cpd_map.svh"

module cpd_timer (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_start,
  input wire logic [15:0] i_us,
  output logic o_done
);

  localparam logic [7:0] UNIT_LAST = 8'(`CPD_UNIT_CYCLES - 1);
  localparam logic [23:0] UNIT_W = 24'(`CPD_UNIT_CYCLES);

  cpd_pkg::cpd_tmr_s_t s_r;
  cpd_pkg::cpd_tmr_s_t s_nxt;
  logic [23:0] elapsed_r;
  logic [15:0] lat_us_r;

  // ----------------------------------------------------------------------
  // Microsecond delay counter
  // ----------------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    if (i_start) begin
      s_nxt.busy = 1'b1;
      s_nxt.done = 1'b0;
      s_nxt.sub = 8'h00;
      s_nxt.us = i_us;
    end else if (s_r.busy) begin
      if (s_r.us == 16'h0000) begin
        s_nxt.busy = 1'b0;
        s_nxt.done = 1'b1;
      end else if (s_r.sub == UNIT_LAST) begin
        s_nxt.sub = 8'h00;
        s_nxt.us = s_r.us - 16'h0001;
      end else begin
        s_nxt.sub = s_r.sub + 8'h01;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign o_done = s_r.done;

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      elapsed_r <= 24'h000000;
      lat_us_r <= 16'h0000;
    end else if (i_start) begin
      elapsed_r <= 24'h000000;
      lat_us_r <= i_us;
    end else if (s_r.busy) begin
      elapsed_r <= elapsed_r + 24'h000001;
    end
  end

  settle_len_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    $rose(s_r.done) |-> elapsed_r == ({8'h00, lat_us_r} * UNIT_W + 24'h000001))
    else $error("settle delay length wrong");

endmodule // cpd_timer

`default_nettype wire

// file: cpd_top.sv
// Added by the designer: strobed register access.
`timescale 1ns/1ns
`default_nettype none
`include "cpd_map.svh"

module cpd_top (
  input wire logic I_CLK,
  input wire logic I_ARST_N,
  input wire logic [`CPD_ADDR_W-1:0] I_ADDR,
  input wire logic [31:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  output logic [31:0] O_RDATA,
  input wire logic I_ADC_VALID,
  input wire logic [`CPD_ADC_W-1:0] I_ADC_I,
  input wire logic [`CPD_ADC_W-1:0] I_ADC_Q,
  output logic O_RF_FIELD_ON,
  output logic O_TX_REG_EN,
  output logic [15:0] O_RX_RSSI_TARGET,
  output logic [7:0] O_RX_RSSI_HYST,
  output logic O_RX_RSSI_LOAD,
  output logic O_CARD_DETECT,
  output logic O_IRQ
);

  cpd_pkg::cpd_top_s_t s_r;
  cpd_pkg::cpd_top_s_t s_nxt;
  logic [2:0] eff_n;
  logic tmr_start;
  logic tmr_done;
  logic chan_clr;
  logic done_i;
  logic done_q;
  logic over_i;
  logic over_q;
  logic [15:0] avg_i;
  logic [15:0] avg_q;
  logic sts_det_clr;

  // Reserved averaging code falls back to the largest legal count
  assign eff_n = (s_r.avg_n > `CPD_AVG_N_MAX) ? `CPD_AVG_N_MAX : s_r.avg_n;
  assign sts_det_clr = I_WR && (I_ADDR == `CPD_ADDR_STATUS) && I_WDATA[`CPD_STS_DET_BIT];

  // ----------------------------------------------------------------------
  // Register file, sequencer and status
  // ----------------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    s_nxt.rssi_load = 1'b0;
    s_nxt.rdata = 32'h0000_0000;
    tmr_start = 1'b0;
    chan_clr = 1'b0;

    if (I_WR) begin
      case (I_ADDR)
        `CPD_ADDR_AVG: s_nxt.avg_n = I_WDATA[2:0];
        `CPD_ADDR_RSSI_TGT: s_nxt.rssi_tgt = I_WDATA[15:0];
        `CPD_ADDR_RSSI_HYST: s_nxt.rssi_hyst = I_WDATA[7:0];
        `CPD_ADDR_CTRL: begin
          s_nxt.det_en = I_WDATA[`CPD_CTRL_EN_BIT];
          s_nxt.rf_off_early = I_WDATA[`CPD_CTRL_RFOFF_BIT];
        end
        `CPD_ADDR_THR: s_nxt.thr = I_WDATA;
        `CPD_ADDR_SETTLE: s_nxt.settle = I_WDATA[15:0];
        `CPD_ADDR_STATUS: s_nxt.sts = s_r.sts & ~I_WDATA[1:0];
        `CPD_ADDR_MASK: s_nxt.msk = I_WDATA[1:0];
        `CPD_ADDR_REF: s_nxt.refv = I_WDATA;
        default: s_nxt.sts = s_r.sts;
      endcase
    end

    if (I_RD) begin
      case (I_ADDR)
        `CPD_ADDR_AVG: s_nxt.rdata = {29'h0000_0000, s_r.avg_n};
        `CPD_ADDR_RSSI_TGT: s_nxt.rdata = {16'h0000, s_r.rssi_tgt};
        `CPD_ADDR_RSSI_HYST: s_nxt.rdata = {24'h00_0000, s_r.rssi_hyst};
        `CPD_ADDR_CTRL: s_nxt.rdata = {24'h00_0000, s_r.det_en, 1'b0, s_r.rf_off_early, 5'h00};
        `CPD_ADDR_THR: s_nxt.rdata = s_r.thr;
        `CPD_ADDR_SETTLE: s_nxt.rdata = {16'h0000, s_r.settle};
        `CPD_ADDR_STATUS: s_nxt.rdata = {30'h0000_0000, s_r.sts};
        `CPD_ADDR_MASK: s_nxt.rdata = {30'h0000_0000, s_r.msk};
        `CPD_ADDR_CMD: s_nxt.rdata = {31'h0000_0000, s_r.st != cpd_pkg::CPD_IDLE};
        `CPD_ADDR_REF: s_nxt.rdata = s_r.refv;
        `CPD_ADDR_MEAS: s_nxt.rdata = {avg_q, avg_i};
        default: s_nxt.rdata = 32'h0000_0000;
      endcase
    end

    case (s_r.st)
      cpd_pkg::CPD_IDLE: begin
        // Commands are ignored while detection is disabled
        if (I_WR && (I_ADDR == `CPD_ADDR_CMD) && s_r.det_en) begin
          if (I_WDATA[`CPD_CMD_MEAS_BIT] || I_WDATA[`CPD_CMD_CAL_BIT]) begin
            s_nxt.calib = I_WDATA[`CPD_CMD_CAL_BIT];
            s_nxt.reg_en = 1'b1;
            s_nxt.rf_on = 1'b1;
            s_nxt.rssi_load = 1'b1;
            tmr_start = 1'b1;
            s_nxt.st = cpd_pkg::CPD_SETTLE;
          end
        end
      end
      cpd_pkg::CPD_SETTLE: begin
        if (tmr_done) begin
          chan_clr = 1'b1;
          s_nxt.st = cpd_pkg::CPD_AVG;
        end
      end
      cpd_pkg::CPD_AVG: begin
        if (done_i && done_q) begin
          s_nxt.st = cpd_pkg::CPD_CMP;
        end
      end
      cpd_pkg::CPD_CMP: begin
        if (s_r.calib) begin
          s_nxt.refv = {avg_q, avg_i};
        end else if (over_i || over_q) begin
          s_nxt.sts[`CPD_STS_DET_BIT] = 1'b1;
        end
        s_nxt.sts[`CPD_STS_DONE_BIT] = 1'b1;
        s_nxt.st = cpd_pkg::CPD_FOFF;
      end
      cpd_pkg::CPD_FOFF: begin
        // Early field drop saves the regulator from driving a dying field
        if (s_r.rf_off_early) begin
          s_nxt.rf_on = 1'b0;
        end
        s_nxt.st = cpd_pkg::CPD_ROFF;
      end
      cpd_pkg::CPD_ROFF: begin
        s_nxt.reg_en = 1'b0;
        s_nxt.rf_on = 1'b0;
        s_nxt.st = cpd_pkg::CPD_IDLE;
      end
      default: begin
        s_nxt.st = cpd_pkg::CPD_IDLE;
        s_nxt.rf_on = 1'b0;
        s_nxt.reg_en = 1'b0;
      end
    endcase
  end

  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      s_r <= '0;
      s_r.st <= cpd_pkg::CPD_IDLE;
      s_r.avg_n <= `CPD_AVG_RST;
      s_r.rssi_tgt <= `CPD_RSSI_TGT_RST;
      s_r.rssi_hyst <= `CPD_RSSI_HYST_RST;
      s_r.thr <= `CPD_THR_RST;
      s_r.settle <= `CPD_SETTLE_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Settle timer and channel averagers
  // ----------------------------------------------------------------------
  cpd_timer u_timer (
    .i_clk(I_CLK),
    .i_arst_n(I_ARST_N),
    .i_start(tmr_start),
    .i_us(s_r.settle),
    .o_done(tmr_done)
  );

  cpd_chan u_chan_i (
    .i_clk(I_CLK),
    .i_arst_n(I_ARST_N),
    .i_clear(chan_clr),
    .i_valid(I_ADC_VALID && (s_r.st == cpd_pkg::CPD_AVG)),
    .i_sample(I_ADC_I),
    .i_n(eff_n),
    .i_ref(s_r.refv[15:0]),
    .i_thr(s_r.thr[15:0]),
    .o_done(done_i),
    .o_over(over_i),
    .o_avg(avg_i)
  );

  cpd_chan u_chan_q (
    .i_clk(I_CLK),
    .i_arst_n(I_ARST_N),
    .i_clear(chan_clr),
    .i_valid(I_ADC_VALID && (s_r.st == cpd_pkg::CPD_AVG)),
    .i_sample(I_ADC_Q),
    .i_n(eff_n),
    .i_ref(s_r.refv[31:16]),
    .i_thr(s_r.thr[31:16]),
    .o_done(done_q),
    .o_over(over_q),
    .o_avg(avg_q)
  );

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign O_RDATA = s_r.rdata;
  assign O_RF_FIELD_ON = s_r.rf_on;
  assign O_TX_REG_EN = s_r.reg_en;
  assign O_RX_RSSI_TARGET = s_r.rssi_tgt;
  assign O_RX_RSSI_HYST = s_r.rssi_hyst;
  assign O_RX_RSSI_LOAD = s_r.rssi_load;
  assign O_CARD_DETECT = s_r.sts[`CPD_STS_DET_BIT];
  assign O_IRQ = |(s_r.sts & s_r.msk);

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  rf_early_off_a: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
    (s_r.rf_off_early && $fell(s_r.reg_en)) |-> !$past(s_r.rf_on))
    else $error("field not dropped before regulator");

  rf_joint_off_a: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
    (!s_r.rf_off_early && $fell(s_r.reg_en)) |-> $fell(s_r.rf_on))
    else $error("field and regulator not dropped together");

  disabled_idle_a: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
    (!s_r.det_en && s_r.st == cpd_pkg::CPD_IDLE) |=> s_r.st == cpd_pkg::CPD_IDLE)
    else $error("cycle started while disabled");

  rssi_tgt_load_a: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
    $rose(s_r.rf_on) |-> (O_RX_RSSI_LOAD && O_RX_RSSI_TARGET == s_r.rssi_tgt))
    else $error("rssi target not loaded at field on");

  rssi_hyst_load_a: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
    O_RX_RSSI_LOAD |-> (s_r.rf_on && O_RX_RSSI_HYST == s_r.rssi_hyst))
    else $error("rssi hysteresis not loaded with field");

  det_set_a: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
    (s_r.st == cpd_pkg::CPD_CMP && !s_r.calib && (over_i || over_q))
      |=> O_CARD_DETECT ##1 (O_CARD_DETECT || $past(sts_det_clr)))
    else $error("detection not flagged");

  det_hold_a: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
    (O_CARD_DETECT && !sts_det_clr) |=> O_CARD_DETECT)
    else $error("detection flag lost without acknowledge");

  settle_first_a: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
    (s_r.st == cpd_pkg::CPD_SETTLE && !tmr_done) |=> s_r.st == cpd_pkg::CPD_SETTLE)
    else $error("averaging started before settle delay");

  detect_cov_c: cover property (@(posedge I_CLK) disable iff (!I_ARST_N)
    $rose(O_CARD_DETECT));
  calib_cov_c: cover property (@(posedge I_CLK) disable iff (!I_ARST_N)
    s_r.st == cpd_pkg::CPD_CMP && s_r.calib);
  early_off_cov_c: cover property (@(posedge I_CLK) disable iff (!I_ARST_N)
    s_r.rf_off_early && $fell(s_r.rf_on));
  settle_cov_c: cover property (@(posedge I_CLK) disable iff (!I_ARST_N)
    s_r.st == cpd_pkg::CPD_SETTLE && tmr_done);
  joint_off_cov_c: cover property (@(posedge I_CLK) disable iff (!I_ARST_N)
    !s_r.rf_off_early && $fell(s_r.reg_en));

  // ----------------------------------------------------------------------
  // Sequencer checks
  // ----------------------------------------------------------------------
  cmd_start_a: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
    (s_r.st == cpd_pkg::CPD_IDLE && s_r.det_en && I_WR && I_ADDR == `CPD_ADDR_CMD
      && (I_WDATA[`CPD_CMD_MEAS_BIT] || I_WDATA[`CPD_CMD_CAL_BIT]))
      |=> (s_r.st == cpd_pkg::CPD_SETTLE && O_RF_FIELD_ON && O_TX_REG_EN))
    else $error("enabled command did not start a cycle");

  rssi_pulse_a: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
    O_RX_RSSI_LOAD |=> !O_RX_RSSI_LOAD)
    else $error("receiver load strobe longer than one cycle");

  avg_field_a: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
    s_r.st == cpd_pkg::CPD_AVG |-> (O_RF_FIELD_ON && O_TX_REG_EN))
    else $error("averaging without field");

  avg_wait_a: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
    (s_r.st == cpd_pkg::CPD_AVG && !(done_i && done_q)) |=> s_r.st == cpd_pkg::CPD_AVG)
    else $error("averaging left before both channels done");

  avg_exit_a: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
    (s_r.st == cpd_pkg::CPD_AVG && done_i && done_q) |=> s_r.st == cpd_pkg::CPD_CMP)
    else $error("compare not entered after averaging");

  cycle_done_a: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
    s_r.st == cpd_pkg::CPD_CMP |=> s_r.sts[`CPD_STS_DONE_BIT])
    else $error("cycle done not flagged");

  calib_quiet_a: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
    (s_r.st == cpd_pkg::CPD_CMP && s_r.calib && !O_CARD_DETECT) |=> !O_CARD_DETECT)
    else $error("calibration raised detection");

  below_thr_a: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
    (s_r.st == cpd_pkg::CPD_CMP && !over_i && !over_q && !O_CARD_DETECT) |=> !O_CARD_DETECT)
    else $error("detection raised below threshold");

  reg_after_field_a: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
    s_r.st == cpd_pkg::CPD_FOFF |=> O_TX_REG_EN)
    else $error("regulator dropped at field step");

  both_off_a: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
    s_r.st == cpd_pkg::CPD_ROFF
      |=> (!O_RF_FIELD_ON && !O_TX_REG_EN && s_r.st == cpd_pkg::CPD_IDLE))
    else $error("cycle did not end with field and regulator off");

  rdata_idle_a: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
    !$past(I_RD) |-> O_RDATA == 32'h0000_0000)
    else $error("read data outside read slot");

endmodule // cpd_top

`default_nettype wire

// file: testbench.sv
`timescale 1ns/1ns
`default_nettype none
`include "cpd_map.svh"

module testbench;
  logic I_CLK = 1'b0;
  logic I_ARST_N = 1'b0;
  logic [10:0] I_ADDR = 11'h000;
  logic [31:0] I_WDATA = 32'h0;
  logic I_WR = 1'b0;
  logic I_RD = 1'b0;
  logic [31:0] O_RDATA;
  logic I_ADC_VALID;
  logic [11:0] I_ADC_I;
  logic [11:0] I_ADC_Q;
  logic O_RF_FIELD_ON;
  logic O_TX_REG_EN;
  logic [15:0] O_RX_RSSI_TARGET;
  logic [7:0] O_RX_RSSI_HYST;
  logic O_RX_RSSI_LOAD;
  logic O_CARD_DETECT;
  logic O_IRQ;
  logic slow = 1'b0;
  logic [15:0] quiet = 16'h0000;
  logic [11:0] lvl_i = 12'h200;
  logic [11:0] lvl_q = 12'h200;
  int failures = 0;
  int checks_done = 0;
  int cyc = 0;

  cpd_top uut (.I_CLK(I_CLK), .I_ARST_N(I_ARST_N), .I_ADDR(I_ADDR),
    .I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA),
    .I_ADC_VALID(I_ADC_VALID), .I_ADC_I(I_ADC_I), .I_ADC_Q(I_ADC_Q),
    .O_RF_FIELD_ON(O_RF_FIELD_ON), .O_TX_REG_EN(O_TX_REG_EN),
    .O_RX_RSSI_TARGET(O_RX_RSSI_TARGET), .O_RX_RSSI_HYST(O_RX_RSSI_HYST),
    .O_RX_RSSI_LOAD(O_RX_RSSI_LOAD), .O_CARD_DETECT(O_CARD_DETECT), .O_IRQ(O_IRQ));

  cpd_card_model card (.i_clk(I_CLK), .i_arst_n(I_ARST_N), .i_field(O_RF_FIELD_ON),
    .i_slow(slow), .i_quiet(quiet), .i_lvl_i(lvl_i), .i_lvl_q(lvl_q),
    .o_valid(I_ADC_VALID), .o_i(I_ADC_I), .o_q(I_ADC_Q));

  always #2 I_CLK = ~I_CLK;

  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  task automatic wrap_up();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  always @(posedge I_CLK) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      wrap_up();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [10:0] a, input logic [31:0] d);
    @(posedge I_CLK);
    I_WR <= 1'b1;
    I_ADDR <= a;
    I_WDATA <= d;
    @(posedge I_CLK);
    I_WR <= 1'b0;
  endtask

  task automatic rdchk(input logic [10:0] a, input logic [31:0] exp);
    @(posedge I_CLK);
    I_RD <= 1'b1;
    I_ADDR <= a;
    @(posedge I_CLK);
    I_RD <= 1'b0;
    #1;
    chk(O_RDATA, exp);
  endtask

  // Start a cycle and time the fall of field and regulator
  task automatic seq(input logic [31:0] cmd, output logic ld, output int rf_t,
    output int rg_t);
    int k;
    wr(`CPD_ADDR_CMD, cmd);
    #1;
    ld = O_RX_RSSI_LOAD & O_RF_FIELD_ON;
    rf_t = -1;
    rg_t = -1;
    for (k = 0; k < 2000 && rg_t < 0; k++) begin
      @(posedge I_CLK);
      #1;
      if (rf_t < 0 && O_RF_FIELD_ON !== 1'b1) rf_t = k;
      if (O_TX_REG_EN !== 1'b1) rg_t = k;
    end
  endtask

  task automatic meas(input logic [2:0] n, input logic [31:0] thr, input logic [11:0] li,
    input logic [11:0] lq, input logic early, input logic det);
    logic ld;
    int rf_t;
    int rg_t;
    wr(`CPD_ADDR_STATUS, 32'h3);
    wr(`CPD_ADDR_AVG, {29'h0, n});
    wr(`CPD_ADDR_THR, thr);
    // Bit 5 is only set with the pa supply fast discharge taken as enabled
    wr(`CPD_ADDR_CTRL, early ? 32'h0000_00a0 : 32'h0000_0080);
    lvl_i <= li;
    lvl_q <= lq;
    seq(32'h1, ld, rf_t, rg_t);
    chk({31'h0, ld}, 32'h1);
    chk(rg_t - rf_t, early ? 32'h1 : 32'h0);
    rdchk(`CPD_ADDR_STATUS, {30'h0, 1'b1, det});
    chk({31'h0, O_CARD_DETECT}, {31'h0, det});
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_reset();
    rdchk(`CPD_ADDR_AVG, 32'h0);
    rdchk(`CPD_ADDR_RSSI_TGT, 32'h0);
    rdchk(`CPD_ADDR_RSSI_HYST, 32'h0);
    rdchk(`CPD_ADDR_CTRL, 32'h0);
    rdchk(`CPD_ADDR_THR, 32'h0);
    rdchk(`CPD_ADDR_SETTLE, 32'h0000_0014);
    rdchk(`CPD_ADDR_STATUS, 32'h0);
    rdchk(11'h3ff, 32'h0);
  endtask

  task automatic t_regs();
    wr(`CPD_ADDR_AVG, 32'h6);
    wr(`CPD_ADDR_RSSI_TGT, 32'h0000_beef);
    wr(`CPD_ADDR_RSSI_HYST, 32'h0000_00a5);
    wr(`CPD_ADDR_CTRL, 32'h0000_ffff);
    wr(`CPD_ADDR_THR, 32'h1234_5678);
    wr(11'h3ff, 32'hffff_ffff);
    rdchk(`CPD_ADDR_AVG, 32'h6);
    rdchk(`CPD_ADDR_RSSI_TGT, 32'h0000_beef);
    rdchk(`CPD_ADDR_RSSI_HYST, 32'h0000_00a5);
    rdchk(`CPD_ADDR_CTRL, 32'h0000_00a0);
    rdchk(`CPD_ADDR_THR, 32'h1234_5678);
    rdchk(11'h3ff, 32'h0);
    wr(`CPD_ADDR_SETTLE, 32'h0);
    wr(`CPD_ADDR_REF, 32'h0200_0200);
  endtask

  task automatic t_off();
    wr(`CPD_ADDR_CTRL, 32'h0000_0020);
    wr(`CPD_ADDR_CMD, 32'h1);
    repeat (5) @(posedge I_CLK);
    #1;
    chk({30'h0, O_RF_FIELD_ON, O_TX_REG_EN}, 32'h0);
    rdchk(`CPD_ADDR_STATUS, 32'h0);
    rdchk(`CPD_ADDR_CMD, 32'h0);
  endtask

  task automatic t_calib();
    logic ld;
    int rf_t;
    int rg_t;
    wr(`CPD_ADDR_CTRL, 32'h0000_0080);
    wr(`CPD_ADDR_AVG, 32'h3);
    lvl_i <= 12'h123;
    lvl_q <= 12'h321;
    seq(32'h2, ld, rf_t, rg_t);
    chk({31'h0, ld}, 32'h1);
    chk({16'h0, O_RX_RSSI_TARGET}, 32'h0000_beef);
    chk({24'h0, O_RX_RSSI_HYST}, 32'h0000_00a5);
    rdchk(`CPD_ADDR_REF, 32'h0321_0123);
    rdchk(`CPD_ADDR_STATUS, 32'h2);
    wr(`CPD_ADDR_REF, 32'h0200_0200);
  endtask

  task automatic t_avg();
    logic [15:0] u;
    for (int n = 0; n < 8; n++) begin
      u = 16'h1 << ((n == 7) ? 6 : n);
      slow <= (n == 6);
      meas(3'(n), {16'hffff, u - 16'h1}, 12'h201, 12'h200, 1'b0, 1'b1);
      meas(3'(n), {16'hffff, u}, 12'h201, 12'h200, 1'b0, 1'b0);
    end
    slow <= 1'b0;
    rdchk(`CPD_ADDR_MEAS, 32'h0200_0201);
    meas(3'h5, {16'd95, 16'hffff}, 12'h200, 12'h203, 1'b1, 1'b1);
    meas(3'h5, {16'd96, 16'hffff}, 12'h200, 12'h203, 1'b1, 1'b0);
    meas(3'h2, {16'hffff, 16'd7}, 12'h1fe, 12'h200, 1'b0, 1'b1);
  endtask

  task automatic t_irq();
    wr(`CPD_ADDR_MASK, 32'h1);
    #1;
    chk({31'h0, O_IRQ}, 32'h1);
    wr(`CPD_ADDR_STATUS, 32'h1);
    #1;
    chk({30'h0, O_CARD_DETECT, O_IRQ}, 32'h0);
    rdchk(`CPD_ADDR_STATUS, 32'h2);
    wr(`CPD_ADDR_MASK, 32'h2);
    #1;
    chk({31'h0, O_IRQ}, 32'h1);
    wr(`CPD_ADDR_STATUS, 32'h2);
    #1;
    chk({31'h0, O_IRQ}, 32'h0);
    rdchk(`CPD_ADDR_MASK, 32'h2);
  endtask

  task automatic t_settle();
    wr(`CPD_ADDR_SETTLE, 32'h1);
    quiet <= 16'd250;
    meas(3'h2, {16'hffff, 16'd4}, 12'h201, 12'h200, 1'b0, 1'b0);
    quiet <= 16'h0000;
  endtask

  initial begin
    repeat (20) @(posedge I_CLK);
    I_ARST_N <= 1'b1;
    t_reset();
    t_regs();
    t_off();
    t_calib();
    t_avg();
    t_irq();
    t_settle();
    wrap_up();
  end
endmodule // testbench

`default_nettype wire
